// [common/key_request_and_reset_control_defs.svh]
`ifndef KEY_REQUEST_AND_RESET_CONTROL_DEFS_SVH
`define KEY_REQUEST_AND_RESET_CONTROL_DEFS_SVH
// ============================================================
// register offsets
`define OFS_CTRL 8'h00
`define OFS_CFG 8'h04
`define OFS_CMD 8'h08
`define OFS_STATUS 8'h0c
`define OFS_KEYS 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_EN 8'h18
`define OFS_IRQ_CLR 8'h1c
// ============================================================
// field positions
`define CTRL_DISP_ON 0
`define CTRL_ADC_REV 1
`define CTRL_INVERT 2
`define CTRL_ALL_ON 3
`define CTRL_PSAVE 4
`define CFG_DUTY_LSB 15
`define CFG_PWM_EN 19
`define CFG_PWM_LSB 20
`define CFG_PORT_SEL 27
`define CMD_SOFT_RST 0
// ============================================================
// reset values
`define CTRL_RST 5'h10
`define CFG_RST 28'h0017800
// ============================================================
// timing
`define PCLK_PERIOD_NS 4
`define T_PERIOD_NS 40000
`define BUSY_NS 1000
`define SCAN_T 10'h0a0
`define ROW_T 10'h020
`define REQ_FIRST_T 10'h142
`define REQ_RETRY_T 10'h2a4
`define FRAME_T 9'h023
`define DUTY_BASE 9'h008
`define KEY_BITS 5'h19
`define READ_BITS 5'h1a
`endif

// [common/key_request_and_reset_control_pkg.sv]
package key_request_and_reset_control_pkg;
    typedef enum logic [1:0] {SC_IDLE, SC_SCAN, SC_FIXED} scan_state_t;
    typedef logic [24:0] key_map_t;
endpackage : key_request_and_reset_control_pkg

// [src/key_request_and_reset_control.sv]
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "key_request_and_reset_control_defs.svh"
// What this block does
// - request goes low 322 T after press when first scan pair agrees
// - after a disagreeing pair and rescan, request low at 676 T
// - while request low, scanning halts and fixed key data holds
// - reset stops oscillator, display off, scan off, key buffer zero
// - in reset: ports, shared pin low; scan high; request released
// - readout during power-on reset returns all ones
// - reset pin held low 10 us; device busy 1 us after release
// - soft reset restores only page through shared pin selection
// - pin reset clears serial state, display settings; power save
// - reset: page 0, column 0, contrast all ones, duty one tenth
// - reset: pwm phase zero, pwm off, pwm value zero, pin is port
// - frame period is 35 T times duty number
// - key readout mode chosen by shift clock low at chip enable rise
// - power save flag follows last key bit, one in power save
// - paired scans repeat while pressed; fixed only when pair matches
// - after readout, request released and scanning may restart
module key_request_and_reset_control #(
    parameter int T_CYCLES = `T_PERIOD_NS / `PCLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire logic shift_clock,
    input wire logic chip_enable,
    input wire logic hardware_reset_input_n,
    input wire logic supply_drop_detect,
    input wire logic [4:0] key_inputs,
    input wire logic serial_data_request_pin_in,
    output logic serial_data_request_pin_out,
    output logic serial_data_request_pin_oe,
    output logic [3:0] scan_drive_lines,
    output logic shared_port_scan_pin,
    output logic [2:0] port_out,
    output logic display_on,
    output logic osc_run,
    output logic frame_toggle,
    output logic busy
);
    import key_request_and_reset_control_pkg::*;

    localparam logic [7:0] BUSY_CYC = 8'(`BUSY_NS / `PCLK_PERIOD_NS);

    // ============================================================
    // input synchronisers
    logic [8:0] s1_ff;
    logic [8:0] s2_ff;
    logic [1:0] prv_ff;
    logic scl_s;
    logic ce_s;
    logic hwrst_n_s;
    logic por_s;
    logic [4:0] k_s;
    assign {scl_s, ce_s, hwrst_n_s, por_s, k_s} = s2_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 9'h040;
            s2_ff <= 9'h040;
            prv_ff <= 2'h0;
        end else begin
            s1_ff <= {shift_clock, chip_enable, hardware_reset_input_n,
                      supply_drop_detect, key_inputs};
            s2_ff <= s1_ff;
            prv_ff <= {scl_s, ce_s};
        end
    end

    // ============================================================
    // row of the scan pair at a given T count, 7 when idle
    function automatic logic [2:0] row_of(input logic [9:0] t);
        logic [9:0] u;
        u = (t < `SCAN_T) ? t : 10'(t - `SCAN_T);
        if (t >= 10'(2 * `SCAN_T))
            row_of = 3'h7;
        else
            row_of = 3'(u / `ROW_T);
    endfunction : row_of

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ============================================================
    // state
    logic pready_ff, nxt_pready;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;
    logic [4:0] ctrl_ff, nxt_ctrl;
    logic [27:0] cfg_ff, nxt_cfg;
    logic [2:0] istat_ff, nxt_istat;
    logic [2:0] ien_ff, nxt_ien;
    logic irq_ff, nxt_irq;
    logic [15:0] tdiv_ff, nxt_tdiv;
    logic [7:0] busy_cnt_ff, nxt_busy_cnt;
    scan_state_t st_ff, nxt_st;
    logic [9:0] tcnt_ff, nxt_tcnt;
    logic [9:0] lim_ff, nxt_lim;
    key_map_t scan_a_ff, nxt_scan_a;
    key_map_t scan_b_ff, nxt_scan_b;
    key_map_t key_fix_ff, nxt_key_fix;
    logic rd_act_ff, nxt_rd_act;
    logic [4:0] rd_idx_ff, nxt_rd_idx;
    logic oe_ff, nxt_oe;
    logic [3:0] scan_ff, nxt_scan;
    logic shared_ff, nxt_shared;
    logic [2:0] port_ff, nxt_port;
    logic [6:0] pwm_cnt_ff, nxt_pwm_cnt;
    logic [8:0] frame_cnt_ff, nxt_frame_cnt;
    logic frame_ff, nxt_frame;
    logic disp_ff, nxt_disp;
    logic osc_ff, nxt_osc;
    logic busy_ff, nxt_busy;

    logic in_reset;
    logic t_tick;
    logic wr_acc;
    logic rd_done;
    logic soft_rst;
    logic [2:0] ev;
    logic [2:0] row;
    logic bitval;
    logic pwm_hi;
    logic [8:0] frame_len;

    assign in_reset = !hwrst_n_s || por_s;
    assign t_tick = (tdiv_ff == 16'(T_CYCLES - 1));
    assign wr_acc = psel && penable && pready_ff && pwrite;
    assign soft_rst = wr_acc && hit(paddr, `OFS_CMD)
                      && pwdata[`CMD_SOFT_RST];
    assign row = (st_ff == SC_SCAN) ? row_of(tcnt_ff) : 3'h7;
    assign pwm_hi = cfg_ff[`CFG_PWM_EN]
                    && (pwm_cnt_ff < cfg_ff[`CFG_PWM_LSB +: 7]);
    assign frame_len = 9'(`FRAME_T * 9'(`DUTY_BASE
                       + 9'(cfg_ff[`CFG_DUTY_LSB +: 2])));
    assign bitval = (rd_idx_ff < `KEY_BITS) ? key_fix_ff[rd_idx_ff]
                                            : ctrl_ff[`CTRL_PSAVE];
    assign rd_done = rd_act_ff && prv_ff[0] && !ce_s
                     && (rd_idx_ff >= `READ_BITS);

    // ============================================================
    // bus, registers and interrupts
    always_comb begin
        nxt_pready = psel && penable && !pready_ff;
        nxt_prdata = 32'h0;
        nxt_pslverr = 1'b0;
        nxt_ctrl = ctrl_ff;
        nxt_cfg = cfg_ff;
        nxt_ien = ien_ff;
        if (psel && penable && !pready_ff) begin
            if (hit(paddr, `OFS_CTRL))
                nxt_prdata = {27'h0, ctrl_ff};
            else if (hit(paddr, `OFS_CFG))
                nxt_prdata = {4'h0, cfg_ff};
            else if (hit(paddr, `OFS_STATUS))
                nxt_prdata = {29'h0, in_reset, busy_cnt_ff != 8'h0,
                              st_ff == SC_FIXED};
            else if (hit(paddr, `OFS_KEYS))
                nxt_prdata = {7'h0, key_fix_ff};
            else if (hit(paddr, `OFS_IRQ_STAT))
                nxt_prdata = {29'h0, istat_ff};
            else if (hit(paddr, `OFS_IRQ_EN))
                nxt_prdata = {29'h0, ien_ff};
            else if (!hit(paddr, `OFS_CMD) && !hit(paddr, `OFS_IRQ_CLR))
                nxt_pslverr = 1'b1;
        end
        if (wr_acc && hit(paddr, `OFS_CTRL))
            nxt_ctrl = pwdata[4:0];
        if (wr_acc && hit(paddr, `OFS_CFG))
            nxt_cfg = pwdata[27:0];
        if (wr_acc && hit(paddr, `OFS_IRQ_EN))
            nxt_ien = pwdata[2:0];
        if (soft_rst)
            nxt_cfg = `CFG_RST;
        if (in_reset) begin
            nxt_ctrl = `CTRL_RST;
            nxt_cfg = `CFG_RST;
        end
        // set wins over clear
        nxt_istat = istat_ff;
        if (wr_acc && hit(paddr, `OFS_IRQ_CLR))
            nxt_istat = istat_ff & ~pwdata[2:0];
        nxt_istat = nxt_istat | ev;
        nxt_irq = |(istat_ff & ien_ff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
            ctrl_ff <= `CTRL_RST;
            cfg_ff <= `CFG_RST;
            istat_ff <= 3'h0;
            ien_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
            istat_ff <= nxt_istat;
            ien_ff <= nxt_ien;
            irq_ff <= nxt_irq;
        end
    end

    // ============================================================
    // scan, readout and pins
    always_comb begin
        nxt_tdiv = (in_reset || t_tick) ? 16'h0 : 16'(tdiv_ff + 16'h1);
        nxt_busy_cnt = (busy_cnt_ff != 8'h0) ? 8'(busy_cnt_ff - 8'h1) : 8'h0;
        if (in_reset)
            nxt_busy_cnt = BUSY_CYC;
        // registered so the pin comes straight from a flop
        nxt_busy = nxt_busy_cnt != 8'h0;
        nxt_st = st_ff;
        nxt_tcnt = tcnt_ff;
        nxt_lim = lim_ff;
        nxt_scan_a = scan_a_ff;
        nxt_scan_b = scan_b_ff;
        nxt_key_fix = key_fix_ff;
        nxt_rd_act = rd_act_ff;
        nxt_rd_idx = rd_idx_ff;
        ev = 3'h0;
        case (st_ff)
            SC_IDLE: begin
                if (busy_cnt_ff == 8'h0 && |k_s) begin
                    nxt_st = SC_SCAN;
                    nxt_tcnt = 10'h0;
                    nxt_lim = `REQ_FIRST_T;
                    nxt_scan_a = '0;
                    nxt_scan_b = '0;
                end
            end
            SC_SCAN: begin
                if (t_tick) begin
                    nxt_tcnt = 10'(tcnt_ff + 10'h1);
                    if (row != 3'h7
                        && (tcnt_ff % `ROW_T) == 10'(`ROW_T - 10'h1)) begin
                        if (tcnt_ff < `SCAN_T)
                            nxt_scan_a[row * 5 +: 5] = k_s;
                        else
                            nxt_scan_b[row * 5 +: 5] = k_s;
                    end
                    if (tcnt_ff == 10'(lim_ff - 10'h1)) begin
                        if (scan_a_ff == scan_b_ff && |scan_a_ff) begin
                            nxt_st = SC_FIXED;
                            nxt_key_fix = scan_a_ff;
                            ev[0] = 1'b1;
                        end else if (|k_s) begin
                            // rescan pair ends at 676 T
                            nxt_tcnt = 10'h0;
                            nxt_lim = 10'(`REQ_RETRY_T - `REQ_FIRST_T);
                            nxt_scan_a = '0;
                            nxt_scan_b = '0;
                            ev[2] = 1'b1;
                        end else begin
                            nxt_st = SC_IDLE;
                        end
                    end
                end
            end
            SC_FIXED: begin
                if (rd_done) begin
                    nxt_st = SC_IDLE;
                    ev[1] = 1'b1;
                end
            end
            default: nxt_st = SC_IDLE;
        endcase
        // key mode when clock low at enable rise
        if (ce_s && !prv_ff[0] && !scl_s) begin
            nxt_rd_act = 1'b1;
            nxt_rd_idx = 5'h0;
        end else if (rd_act_ff && !ce_s) begin
            nxt_rd_act = 1'b0;
        end else if (rd_act_ff && prv_ff[1] && !scl_s
                     && rd_idx_ff < `READ_BITS) begin
            nxt_rd_idx = 5'(rd_idx_ff + 5'h1);
        end
        // data line floats high in supply reset
        nxt_oe = rd_act_ff ? !bitval : (st_ff == SC_FIXED);
        nxt_pwm_cnt = t_tick ? 7'(pwm_cnt_ff + 7'h1) : pwm_cnt_ff;
        nxt_frame_cnt = frame_cnt_ff;
        nxt_frame = frame_ff;
        // frame of 35 T per duty line
        if (t_tick) begin
            nxt_frame_cnt = 9'(frame_cnt_ff + 9'h1);
            if (frame_cnt_ff >= 9'(frame_len - 9'h1)) begin
                nxt_frame_cnt = 9'h0;
                nxt_frame = !frame_ff;
            end
        end
        nxt_scan = 4'hf;
        for (int i = 1; i < 5; i++) begin
            if (row != 3'h7)
                nxt_scan[i - 1] = (row == 3'(i));
        end
        nxt_shared = cfg_ff[`CFG_PORT_SEL] ? (row == 3'h0) : pwm_hi;
        nxt_port = {3{pwm_hi}};
        nxt_disp = ctrl_ff[`CTRL_DISP_ON];
        nxt_osc = 1'b1;
        if (in_reset) begin
            nxt_st = SC_IDLE;
            nxt_key_fix = '0;
            nxt_tcnt = 10'h0;
            nxt_pwm_cnt = 7'h0;
            nxt_frame_cnt = 9'h0;
            nxt_oe = 1'b0;
            nxt_scan = 4'hf;
            nxt_shared = 1'b0;
            nxt_port = 3'h0;
            nxt_disp = 1'b0;
            nxt_osc = 1'b0;
            ev = 3'h0;
            if (!hwrst_n_s) begin
                nxt_rd_act = 1'b0;
                nxt_rd_idx = 5'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdiv_ff <= 16'h0;
            busy_cnt_ff <= 8'h0;
            st_ff <= SC_IDLE;
            tcnt_ff <= 10'h0;
            lim_ff <= `REQ_FIRST_T;
            scan_a_ff <= '0;
            scan_b_ff <= '0;
            key_fix_ff <= '0;
            rd_act_ff <= 1'b0;
            rd_idx_ff <= 5'h0;
            oe_ff <= 1'b0;
            scan_ff <= 4'hf;
            shared_ff <= 1'b0;
            port_ff <= 3'h0;
            pwm_cnt_ff <= 7'h0;
            frame_cnt_ff <= 9'h0;
            frame_ff <= 1'b0;
            disp_ff <= 1'b0;
            osc_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            tdiv_ff <= nxt_tdiv;
            busy_cnt_ff <= nxt_busy_cnt;
            st_ff <= nxt_st;
            tcnt_ff <= nxt_tcnt;
            lim_ff <= nxt_lim;
            scan_a_ff <= nxt_scan_a;
            scan_b_ff <= nxt_scan_b;
            key_fix_ff <= nxt_key_fix;
            rd_act_ff <= nxt_rd_act;
            rd_idx_ff <= nxt_rd_idx;
            oe_ff <= nxt_oe;
            scan_ff <= nxt_scan;
            shared_ff <= nxt_shared;
            port_ff <= nxt_port;
            pwm_cnt_ff <= nxt_pwm_cnt;
            frame_cnt_ff <= nxt_frame_cnt;
            frame_ff <= nxt_frame;
            disp_ff <= nxt_disp;
            osc_ff <= nxt_osc;
            busy_ff <= nxt_busy;
        end
    end

    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    // open drain: only ever pulls low
    assign serial_data_request_pin_out = 1'b0;
    assign serial_data_request_pin_oe = oe_ff;
    assign scan_drive_lines = scan_ff;
    assign shared_port_scan_pin = shared_ff;
    assign port_out = port_ff;
    assign display_on = disp_ff;
    assign osc_run = osc_ff;
    assign frame_toggle = frame_ff;
    assign busy = busy_ff;

    // ============================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [9:0] since_ff;
    logic [1:0] retry_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_ff <= 10'h0;
            retry_ff <= 2'h0;
        end else if (st_ff != SC_SCAN) begin
            since_ff <= 10'h0;
            retry_ff <= 2'h0;
        end else if (t_tick) begin
            since_ff <= 10'(since_ff + 10'h1);
            if (ev[2] && retry_ff != 2'h3)
                retry_ff <= 2'(retry_ff + 2'h1);
        end
    end

    property p_first;
        ev[0] && retry_ff == 2'h0 |-> since_ff == 10'(`REQ_FIRST_T - 10'h1);
    endproperty
    a_first: assert property (p_first)
        else $error("first request late");
    property p_retry;
        ev[0] && retry_ff == 2'h1 |-> since_ff == 10'(`REQ_RETRY_T - 10'h1);
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry request late");
    property p_hold;
        st_ff == SC_FIXED && !in_reset |=> $stable(key_fix_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("fixed keys changed");
    property p_rst_pins;
        in_reset |=> scan_ff == 4'hf && port_ff == 3'h0 && !oe_ff
                     && !shared_ff && !osc_ff && !disp_ff;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("reset pins");
    property p_rst_keys;
        in_reset |=> key_fix_ff == '0 && st_ff == SC_IDLE;
    endproperty
    a_rst_keys: assert property (p_rst_keys)
        else $error("keys not clear");
    property p_busy;
        $rose(hwrst_n_s) && !por_s |-> busy[*8];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy missing");
    property p_soft;
        soft_rst && !in_reset |=> cfg_ff == `CFG_RST && $stable(ctrl_ff);
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset scope");
    property p_psf;
        rd_act_ff && ce_s && rd_idx_ff == `KEY_BITS && !in_reset
        |=> oe_ff == !$past(ctrl_ff[`CTRL_PSAVE]);
    endproperty
    a_psf: assert property (p_psf)
        else $error("flag bit wrong");
    property p_release;
        rd_done && st_ff == SC_FIXED && !in_reset |-> ##2 !oe_ff;
    endproperty
    a_release: assert property (p_release)
        else $error("no release");
endmodule : key_request_and_reset_control

// [test/key_host_model.sv]
`timescale 1ns/1ps
// ============================================================
// host side: reads the key word over the link
module key_host_model (
    input wire logic request_level,
    output logic shift_clock,
    output logic chip_enable
);
    // link clock stands still between frames
    initial begin
        shift_clock = 1'b0;
        chip_enable = 1'b0;
    end
    // caller reads after request seen low, or during supply reset
    task automatic read_keys(output logic [25:0] d);
        // step off the system clock edge so sampling is not a race
        #1;
        chip_enable = 1'b1;
        #40;
        for (int i = 0; i < 26; i++) begin
            d[i] = request_level;
            shift_clock = 1'b1;
            #40;
            shift_clock = 1'b0;
            #40;
        end
        chip_enable = 1'b0;
        #40;
    endtask : read_keys
endmodule : key_host_model

// [test/key_request_and_reset_control_tb.sv]
`timescale 1ns/1ps
`include "key_request_and_reset_control_defs.svh"
// ============================================================
// bench top
module key_request_and_reset_control_tb;
    import key_request_and_reset_control_pkg::*;
    localparam int T = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic shift_clock, chip_enable, hardware_reset_input_n;
    logic supply_drop_detect, serial_data_request_pin_out;
    logic serial_data_request_pin_oe, shared_port_scan_pin;
    logic display_on, osc_run, frame_toggle, busy;
    logic [4:0] key_inputs, k;
    logic [3:0] scan_drive_lines;
    logic [2:0] port_out;
    logic [25:0] d;
    int mismatches = 0;
    int n_tests = 0;
    int c;
    // open drain with pull-up
    wire logic req_line = serial_data_request_pin_oe ?
        serial_data_request_pin_out : 1'b1;
    key_request_and_reset_control #(.T_CYCLES(T))
        i_key_request_and_reset_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .irq, .shift_clock, .chip_enable,
        .hardware_reset_input_n, .supply_drop_detect, .key_inputs,
        .serial_data_request_pin_in(req_line),
        .serial_data_request_pin_out, .serial_data_request_pin_oe,
        .scan_drive_lines, .shared_port_scan_pin, .port_out,
        .display_on, .osc_run, .frame_toggle, .busy);
    key_host_model i_key_host_model (.request_level(req_line),
        .shift_clock, .chip_enable);
    // ========================================================
    // helpers
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask : chk
    function automatic logic pick(input int s);
        return s == 0 ? req_line : (s == 1 ? busy : frame_toggle);
    endfunction : pick
    task automatic wait_sig(input int s, input logic v, input int lim);
        c = 0;
        // look mid-cycle, where registered outputs have settled
        do begin
            @(negedge pclk);
            c++;
        end while (pick(s) !== v && c < lim);
        if (pick(s) !== v) begin
            chk(pick(s), v);
            complete_run();
        end
        @(posedge pclk);
    endtask : wait_sig
    // holds the request until pready; bounded wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        c = pslverr;
        // the next rising edge is the one that samples pready high
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            chk(pready, 1'b1);
            complete_run();
        end
    endtask : apb
    function automatic logic [24:0] kmap(input logic [4:0] x);
        return {x, x, x, x, x};
    endfunction : kmap
    // press a, switch to b at 100 T, expect request near lo T
    task automatic press(input logic [4:0] a, input logic [4:0] b,
                         input int lo, input logic power_save_status_flag);
        int c0;
        c0 = 0;
        key_inputs <= a;
        if (b != a) begin
            c0 = 100 * T;
            repeat (c0) @(posedge pclk);
            key_inputs <= b;
        end
        wait_sig(0, 1'b0, 3000);
        c += c0;
        // never before the rule's count of periods
        chk(c inside {[lo*T:lo*T+40]}, 1);
        key_inputs <= ~b;
        repeat (60) @(posedge pclk);
        key_inputs <= 5'h00;
        chk(req_line, 1'b0);
        i_key_host_model.read_keys(d);
        @(posedge pclk);
        chk(d, {power_save_status_flag, kmap(b)});
        wait_sig(0, 1'b1, 40);
        $display("end of test: key press");
    endtask : press
    // ========================================================
    // stimulus
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hardware_reset_input_n = 1'b1;
        supply_drop_detect = 1'b0;
        key_inputs = 5'h00;
        void'($urandom(32'h02fc));
        repeat (20) @(posedge pclk);
        chk({scan_drive_lines, shared_port_scan_pin, port_out, display_on,
             osc_run, serial_data_request_pin_oe}, 11'h780);
        presetn <= 1'b1;
        wait_sig(1, 1'b0, 400);
        apb(0, `OFS_CTRL, 0);
        chk(rd, 32'h10);
        apb(0, `OFS_CFG, 0);
        chk(rd, 32'h0017800);
        apb(0, 8'h20, 0);
        chk(c, 1);
        apb(1, `OFS_IRQ_EN, 1);
        $display("end of test: reset values");
        for (int i = 0; i < 3; i++) begin
            k = 5'($urandom_range(31, 1));
            press(k, k, 322, 1'b1);
            chk(irq, 1'b1);
            apb(1, `OFS_IRQ_CLR, 32'h7);
            repeat (3) @(posedge pclk);
            chk(irq, 1'b0);
        end
        // masked event and cleared power save
        apb(1, `OFS_IRQ_EN, 0);
        apb(1, `OFS_CTRL, 0);
        press(5'h01, 5'h02, 676, 1'b0);
        chk(irq, 1'b0);
        for (int dd = 0; dd < 3; dd++) begin
            apb(1, `OFS_CFG, 32'h7800 | (dd << 15));
            wait_sig(2, !frame_toggle, 4000);
            wait_sig(2, !frame_toggle, 4000);
            chk(c, 35 * (8 + dd) * T);
        end
        apb(1, `OFS_CTRL, 32'h0f);
        apb(1, `OFS_CFG, 32'h8000001);
        apb(1, `OFS_CMD, 1);
        apb(0, `OFS_CTRL, 0);
        chk(rd, 32'h0f);
        chk({display_on, osc_run}, 2'h3);
        apb(0, `OFS_CFG, 0);
        chk(rd, 32'h0017800);
        hardware_reset_input_n <= 1'b0;
        repeat (2500) @(posedge pclk);
        chk({scan_drive_lines, display_on, osc_run,
             serial_data_request_pin_oe}, 7'h78);
        hardware_reset_input_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(busy, 1'b1);
        wait_sig(1, 1'b0, 400);
        chk(c > 230, 1);
        apb(0, `OFS_CTRL, 0);
        chk(rd, 32'h10);
        supply_drop_detect <= 1'b1;
        repeat (10) @(posedge pclk);
        i_key_host_model.read_keys(d);
        @(posedge pclk);
        chk(d, 26'h3ffffff);
        supply_drop_detect <= 1'b0;
        $display("end of test: resets");
        complete_run();
    end
endmodule : key_request_and_reset_control_tb
